/* pkg/ds3p_pkg.sv */
// Shared constants for the gapped-clock pre-processor and the line channel.
package ds3p_pkg;
   // Attenuator control register addresses, one per channel.
   localparam logic [7:0] ATTEN_CTRL_ADDR_CH0 = 8'h07;
   localparam logic [7:0] ATTEN_CTRL_ADDR_CH1 = 8'h0f;
   localparam logic [7:0] ATTEN_CTRL_ADDR_CH2 = 8'h17;
   localparam int BIT_BW_SEL_LO = 0;
   localparam int BIT_IN_TX_PATH = 1;
   localparam int BIT_BW_SEL_HI = 2;
   localparam int BIT_ATTEN_RESET = 3;
   localparam int BIT_RECOVERY_DISABLE = 4;
   localparam int CTRL_BITS = 5;
   localparam logic [2:0] CTRL_UNUSED_READ = 3'h0;
   localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Burst shapes: pulses and slots of each burst kind.
   localparam int P1_PULSES = 7;
   localparam int P1_SLOTS = 8;
   localparam int P2_PULSES = 5;
   localparam int P2_SLOTS = 6;
   localparam int P3_PULSES = 6;
   localparam int P3_SLOTS = 6;
   localparam int P1_BURSTS = 63;
   localparam int P2_BURSTS_A = 36;
   localparam int P2_BURSTS_B = 35;
   localparam int MAJOR_A_REPEATS = 2;
   localparam int PULSES_PER_SUPER = 1864;
   // Nominal pulse period and the local clock period.
   localparam real STS1_PERIOD_NS = 19.3;
   localparam real REF_PERIOD_NS = 5.0;
   // Slot length in ref_clk cycles used on the link by default.
   localparam int LINK_SLOT_CYCLES = 8;
   localparam int MAX_MISSING_PULSES = 59;
   typedef enum logic [1:0] {DS3P_P1, DS3P_P2, DS3P_P3} ds3p_burst_t;
endpackage

/* pkg/ds3p_link_if.sv */
// Gapped DS3 clock and data link between mapper and line channel.
`timescale 1ns/1ps
interface ds3p_link_if;
   logic lclk;
   logic ldata;
   modport mapper (output lclk, output ldata);
   modport liu (input lclk, input ldata);
endinterface // ds3p_link_if

/* hdl/ds3p_liu_channel.sv */
// Line channel end: attenuator control registers and gapped-clock sampler.
`timescale 1ns/1ps
module ds3p_liu_channel #(
   parameter int SLOT = ds3p_pkg::LINK_SLOT_CYCLES,
   parameter int LINK_CH = 0
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   ds3p_link_if.liu link,
   input wire logic host_mode,
   input wire logic atten_path_select,
   input wire logic atten_bandwidth_sel_lo,
   input wire logic atten_bandwidth_sel_hi,
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [2:0] atten_in_transmit_path,
   output logic [2:0] narrow_bandwidth,
   output logic [2:0] protection_recovery_en,
   output logic [2:0] atten_reset,
   output logic clock_gap_exceeded,
   output logic sample_lost,
   output logic out_valid,
   output logic out_bit,
   input wire logic out_ready
);
   localparam int GAP_LIMIT = (ds3p_pkg::MAX_MISSING_PULSES + 1) * SLOT;
   localparam int GW = $clog2(GAP_LIMIT + 2);
   localparam int NS = 6;
   typedef struct packed {
      logic [NS-1:0] meta;
      logic [NS-1:0] sync;
      logic clk_prev;
      logic [2:0][ds3p_pkg::CTRL_BITS-1:0] ctrl;
      logic [7:0] rdata;
      logic [GW-1:0] gap;
      logic [1:0] cnt;
      logic b0;
      logic b1;
      logic lost;
   } ds3p_liu_state_t;
   ds3p_liu_state_t s;
   ds3p_liu_state_t next_s;
   logic [2:0] hit;
   logic hostm;
   logic rise;
   logic pop;
   ////////////////////////////////////////////////////////////////////////
   // Register decode and effective controls.
   assign hit[0] = reg_addr == ds3p_pkg::ATTEN_CTRL_ADDR_CH0;
   assign hit[1] = reg_addr == ds3p_pkg::ATTEN_CTRL_ADDR_CH1;
   assign hit[2] = reg_addr == ds3p_pkg::ATTEN_CTRL_ADDR_CH2;
   assign hostm = s.sync[5];
   // Straps are synchronised, so a change takes effect two edges later.
   always_comb
   begin
      for (int c = 0; c < 3; c++)
      begin
         if (hostm)
         begin
            atten_in_transmit_path[c] = s.ctrl[c][ds3p_pkg::BIT_IN_TX_PATH];
            narrow_bandwidth[c] = s.ctrl[c][ds3p_pkg::BIT_BW_SEL_LO] &
               ~s.ctrl[c][ds3p_pkg::BIT_BW_SEL_HI];
            protection_recovery_en[c] = ~s.ctrl[c][ds3p_pkg::BIT_RECOVERY_DISABLE];
            atten_reset[c] = s.ctrl[c][ds3p_pkg::BIT_ATTEN_RESET];
         end
         else
         begin
            atten_in_transmit_path[c] = s.sync[4];
            narrow_bandwidth[c] = s.sync[3] & ~s.sync[2];
            protection_recovery_en[c] = 1'b1;
            atten_reset[c] = 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Sampler, gap watch and two-entry output buffer.
   assign rise = s.sync[1] & ~s.clk_prev;
   assign pop = out_valid && out_ready;
   always_comb
   begin
      next_s = s;
      next_s.meta = {host_mode, atten_path_select, atten_bandwidth_sel_lo,
         atten_bandwidth_sel_hi, link.lclk, link.ldata};
      next_s.sync = s.meta;
      next_s.clk_prev = s.sync[1];
      if (reg_sel && reg_wr)
      begin
         for (int c = 0; c < 3; c++)
         begin
            if (hit[c])
            begin
               next_s.ctrl[c] = reg_wdata[ds3p_pkg::CTRL_BITS-1:0];
            end
         end
      end
      if (reg_sel && !reg_wr)
      begin
         next_s.rdata = ds3p_pkg::READ_UNMAPPED;
         for (int c = 0; c < 3; c++)
         begin
            if (hit[c])
            begin
               next_s.rdata = {ds3p_pkg::CTRL_UNUSED_READ, s.ctrl[c]};
            end
         end
      end
      // Up to 59 missing pulses are normal traffic, not a lost clock.
      if (rise)
      begin
         next_s.gap = '0;
      end
      else if (s.gap <= GW'(GAP_LIMIT))
      begin
         next_s.gap = s.gap + GW'(1);
      end
      if (pop)
      begin
         next_s.b0 = s.b1;
         next_s.cnt = s.cnt - 2'h1;
      end
      if (rise)
      begin
         if (next_s.cnt == 2'h0)
         begin
            next_s.b0 = s.sync[0];
            next_s.cnt = 2'h1;
         end
         else if (next_s.cnt == 2'h1)
         begin
            next_s.b1 = s.sync[0];
            next_s.cnt = 2'h2;
         end
         else
         begin
            next_s.lost = 1'b1;
         end
      end
      // The attenuator reset bit flushes the channel's buffered bits.
      if (atten_reset[LINK_CH])
      begin
         next_s.cnt = 2'h0;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.ctrl <= {3{ds3p_pkg::CTRL_RESET}};
         s.gap <= GW'(GAP_LIMIT + 1);
      end
      else
      begin
         s <= next_s;
      end
   end
   assign reg_rdata = s.rdata;
   assign clock_gap_exceeded = s.gap > GW'(GAP_LIMIT);
   assign sample_lost = s.lost;
   assign out_valid = s.cnt != 2'h0;
   assign out_bit = s.b0;
endmodule // ds3p_liu_channel

/* hdl/ds3p_mapper_preproc.sv */
// Mapper end: elastic store and super-pattern gapped clock generator.
`timescale 1ns/1ps
module ds3p_mapper_preproc #(
   parameter int DEPTH = 16,
   parameter int PREFILL = 8,
   parameter int SLOT = ds3p_pkg::LINK_SLOT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   ds3p_link_if.mapper link,
   input wire logic in_valid,
   input wire logic in_bit,
   output logic in_ready,
   output logic running,
   output logic underflow,
   output logic super_done,
   output logic [10:0] super_pulses
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int SW = $clog2(SLOT);
   localparam int LAST_BURST = ds3p_pkg::P1_BURSTS + ds3p_pkg::P2_BURSTS_A - 1;
   localparam int LAST_MAJOR = ds3p_pkg::MAJOR_A_REPEATS;
   typedef enum logic {DS3P_FILL, DS3P_RUN} ds3p_phase_t;
   typedef struct packed {
      logic [DEPTH-1:0] store;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
      ds3p_phase_t phase;
      logic [SW-1:0] div;
      logic [1:0] major;
      logic [6:0] burst;
      logic [2:0] pos;
      logic pulse_slot;
      logic lclk;
      logic ldata;
      logic under;
      logic done;
      logic [10:0] pcount;
      logic [10:0] plast;
   } ds3p_gen_state_t;
   ds3p_gen_state_t s;
   ds3p_gen_state_t next_s;
   logic push;
   logic pop;
   logic tick;
   logic half;
   ds3p_pkg::ds3p_burst_t kind;
   logic [2:0] slot_last;
   logic [2:0] pulse_cnt;
   logic is_pulse;
   logic burst_end;
   logic seq_end;
   logic super_end;
   logic [10:0] pc;
   ////////////////////////////////////////////////////////////////////////
   // Elastic store handshake.
   // The store is a power-of-two ring, so the pointers wrap by overflow.
   assign in_ready = s.count != CW'(DEPTH);
   assign push = in_valid && in_ready;
   assign pop = tick && (s.phase == DS3P_RUN) && is_pulse && (s.count != '0);
   ////////////////////////////////////////////////////////////////////////
   // Slot divider: one slot of SLOT cycles stands for one line period.
   assign tick = s.div == SW'(SLOT - 1);
   assign half = s.div == SW'(SLOT / 2 - 1);
   ////////////////////////////////////////////////////////////////////////
   // Burst kind of the slot about to start.
   // Both long sequences hold the same number of bursts, so one end index serves both.
   always_comb
   begin
      if (s.burst < 7'(ds3p_pkg::P1_BURSTS))
      begin
         kind = ds3p_pkg::DS3P_P1;
      end
      else if (s.major == 2'(LAST_MAJOR) && s.burst == 7'(LAST_BURST))
      begin
         kind = ds3p_pkg::DS3P_P3;
      end
      else
      begin
         kind = ds3p_pkg::DS3P_P2;
      end
   end
   always_comb
   begin
      unique case (kind)
         ds3p_pkg::DS3P_P1:
         begin
            slot_last = 3'(ds3p_pkg::P1_SLOTS - 1);
            pulse_cnt = 3'(ds3p_pkg::P1_PULSES);
         end
         ds3p_pkg::DS3P_P2:
         begin
            slot_last = 3'(ds3p_pkg::P2_SLOTS - 1);
            pulse_cnt = 3'(ds3p_pkg::P2_PULSES);
         end
         ds3p_pkg::DS3P_P3:
         begin
            slot_last = 3'(ds3p_pkg::P3_SLOTS - 1);
            pulse_cnt = 3'(ds3p_pkg::P3_PULSES);
         end
         default:
         begin
            slot_last = '0;
            pulse_cnt = '0;
         end
      endcase
   end
   // A burst holds its pulses first and its gap slot, if any, last.
   assign is_pulse = s.pos < pulse_cnt;
   assign burst_end = s.pos == slot_last;
   assign seq_end = burst_end && (s.burst == 7'(LAST_BURST));
   assign super_end = seq_end && (s.major == 2'(LAST_MAJOR));
   assign pc = s.pcount + 11'(is_pulse);
   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      if (push)
      begin
         next_s.store[s.wr_ptr] = in_bit;
         next_s.wr_ptr = s.wr_ptr + PW'(1);
      end
      if (pop)
      begin
         next_s.ldata = s.store[s.rd_ptr];
         next_s.rd_ptr = s.rd_ptr + PW'(1);
      end
      next_s.count = s.count + CW'(push) - CW'(pop);
      if (tick)
      begin
         next_s.div = '0;
      end
      else
      begin
         next_s.div = s.div + SW'(1);
      end
      // Clock and data leave one flop bank together, so the far end sees them aligned.
      if (half)
      begin
         next_s.lclk = 1'b0;
      end
      unique case (s.phase)
         DS3P_FILL:
         begin
            // The prefill absorbs input jitter against the steady output pattern.
            if (tick && s.count >= CW'(PREFILL))
            begin
               next_s.phase = DS3P_RUN;
            end
         end
         DS3P_RUN:
         begin
            if (tick)
            begin
               // The pattern never stalls; an empty store is flagged instead.
               next_s.lclk = is_pulse;
               next_s.pulse_slot = is_pulse;
               next_s.pcount = pc;
               if (is_pulse && s.count == '0)
               begin
                  next_s.under = 1'b1;
               end
               if (!burst_end)
               begin
                  next_s.pos = s.pos + 3'(1);
               end
               else
               begin
                  next_s.pos = '0;
                  if (!seq_end)
                  begin
                     next_s.burst = s.burst + 7'(1);
                  end
                  else
                  begin
                     next_s.burst = '0;
                     if (super_end)
                     begin
                        next_s.major = '0;
                        next_s.pcount = '0;
                        next_s.plast = pc;
                        next_s.done = 1'b1;
                     end
                     else
                     begin
                        next_s.major = s.major + 2'(1);
                     end
                  end
               end
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign link.lclk = s.lclk;
   assign link.ldata = s.ldata;
   assign running = s.phase == DS3P_RUN;
   assign underflow = s.under;
   assign super_done = s.done;
   assign super_pulses = s.plast;
endmodule // ds3p_mapper_preproc

/* test/ds3p_link_monitor.sv */
// Checker of the gapped link clock burst shape.
`timescale 1ns/1ps
module ds3p_link_monitor #(
   parameter int SLOT = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic lclk
);
   logic prev, seen, bnd;
   int gap, run, n7, s5, tot;
   logic rise, miss;
   assign rise = lclk && !prev;
   // A slot without a rising edge ends a burst; the six-pulse burst merges with the next seven.
   assign miss = seen && gap == SLOT && !rise;
   ////////////////////
   always_ff @(posedge ref_clk)
   begin
      prev <= lclk;
      gap <= rise ? 1 : gap + 1;
      if (rise)
      begin
         seen <= 1'b1;
         run <= run + 1;
         tot <= tot + 1;
      end
      if (miss)
      begin
         run <= 0;
         n7 <= (run == 13) ? 0 : n7 + int'(run == 7);
         s5 <= (run == 5) ? s5 + 1 : 0;
         tot <= (run == 13) ? 0 : tot;
         bnd <= bnd || run == 13;
      end
      if (!rst_n)
      begin
         {prev, seen, bnd} <= 3'h0;
         {gap, run, n7, s5, tot} <= '0;
      end
   end
   ////////////////////
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_slot_min: assert property (rise && seen |-> gap >= SLOT)
      else $error("link pulse too soon");
   a_gap_single: assert property (seen |-> gap <= 2 * SLOT)
      else $error("link gap too long");
   a_burst_shape: assert property (miss |-> run == 5 || run == 7 || run == 13)
      else $error("bad burst length");
   a_run_ceiling: assert property (seen |-> run <= 13)
      else $error("burst too long");
   a_major_a_split: assert property (miss && run == 7 && s5 != 0 |-> s5 == 36)
      else $error("bad five burst count");
   a_major_b_split: assert property (miss && run == 13 |-> s5 == 35)
      else $error("bad five burst count before six");
   a_seven_total: assert property (miss && run == 13 && bnd |-> n7 == 188)
      else $error("bad seven burst count");
   a_super_pulses: assert property (miss && run == 13 && bnd |-> tot == 1864)
      else $error("bad super pattern pulse count");
endmodule // ds3p_link_monitor

/* test/tb_top.sv */
// Bench joining mapper and line channel ends.
`timescale 1ns/1ps
module tb_top;
   localparam int SLOT = 4;
   logic ref_clk = 1'b0, rst_n = 1'b0, host_mode = 1'b1;
   logic aps = 1'b0, bw_lo = 1'b0, bw_hi = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, q;
   logic [2:0] atx, nbw, pre, are, bad = 3'h0;
   logic gapx, lost, ov, ob, ordy = 1'b0, iv = 1'b0, ib = 1'b0, irdy, und;
   logic run, sdone, live = 1'b0, stream_on = 1'b0;
   logic [10:0] spul;
   int nsup = 0;
   logic [7:0] adr [3] = '{ds3p_pkg::ATTEN_CTRL_ADDR_CH0, ds3p_pkg::ATTEN_CTRL_ADDR_CH1, ds3p_pkg::ATTEN_CTRL_ADDR_CH2};
   logic sent [$];
   int miscompares = 0, total_checks = 0;
   ds3p_link_if link();
   ds3p_mapper_preproc #(.SLOT(SLOT)) ds3p_mapper_preproc_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
      .in_valid(iv), .in_bit(ib), .in_ready(irdy), .running(run), .underflow(und), .super_done(sdone),
      .super_pulses(spul));
   ds3p_liu_channel #(.SLOT(SLOT)) ds3p_liu_channel_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
      .host_mode(host_mode), .atten_path_select(aps), .atten_bandwidth_sel_lo(bw_lo), .atten_bandwidth_sel_hi(bw_hi),
      .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .atten_in_transmit_path(atx), .narrow_bandwidth(nbw), .protection_recovery_en(pre), .atten_reset(are),
      .clock_gap_exceeded(gapx), .sample_lost(lost), .out_valid(ov), .out_bit(ob), .out_ready(ordy));
   ds3p_link_monitor #(.SLOT(SLOT)) ds3p_link_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n), .lclk(link.lclk));
   ////////////////////
   function automatic logic [7:0] rb(input logic [7:0] w);
      return {ds3p_pkg::CTRL_UNUSED_READ, w[4:0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_count(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      {reg_sel, reg_wr, reg_addr, reg_wdata} <= {2'h3, a, v};
      @(posedge ref_clk);
      {reg_sel, reg_wr} <= 2'h0;
   endtask
   // Address is held two edges so either a direct or a registered read settles.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      {reg_sel, reg_wr, reg_addr} <= {2'h2, a};
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      v = reg_rdata;
      @(posedge ref_clk);
      reg_sel <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////
   initial
      forever #2.5 ref_clk = ~ref_clk;
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      end_of_test();
   end
   // Random feed and random stalls on the output side; the queue holds bits still in flight.
   always @(posedge ref_clk)
      if (rst_n)
      begin
         if (iv && irdy)
            sent.push_back(ib);
         if (ov && ordy)
            chk("stream_bit", {7'h0, sent.size() > 0 ? sent.pop_front() : ~ob}, {7'h0, ob});
         if (sdone)
         begin
            chk_count("super_pulses", 16'(ds3p_pkg::PULSES_PER_SUPER), {5'h0, spul});
            nsup++;
         end
         // Feeding starts only after the register tests, whose writes may flush the channel.
         if (!iv || irdy)
         begin
            iv <= stream_on && (($urandom % 4) != 0);
            ib <= 1'($urandom);
         end
         // Never two stall cycles in a row, so the receiver drains faster than pulses come.
         ordy <= ~ordy | 1'($urandom);
         live <= live | ov;
         if (live)
            bad <= bad | {und, lost, gapx};
      end
   initial
   begin
      void'($urandom(32'h3c7421d4));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 3; c++)
      begin
         rd(adr[c], q);
         chk("ctrl_reset", {3'h0, ds3p_pkg::CTRL_RESET}, q);
      end
      chk("reset_bw", 8'h07, {5'h0, nbw});
      chk("reset_recovery", 8'h07, {5'h0, pre});
      for (int k = 0; k < 4; k++)
         for (int c = 0; c < 3; c++)
         begin
            d = (k == 0) ? 8'hff : 8'($urandom);
            wr(adr[c], d);
            rd(adr[c], q);
            chk("ctrl_read", rb(d), q);
            chk("tx_path", {7'h0, d[1]}, {7'h0, atx[c]});
            chk("recovery", {7'h0, !d[4]}, {7'h0, pre[c]});
            chk("narrow_bw", {7'h0, d[0] && !d[2]}, {7'h0, nbw[c]});
            chk("atten_reset", {7'h0, d[3]}, {7'h0, are[c]});
         end
      rd(8'h06, q);
      chk("unmapped", ds3p_pkg::READ_UNMAPPED, q);
      wr(adr[0], 8'h10);
      $display("test registers done");
      for (int v = 0; v < 2; v++)
      begin
         @(posedge ref_clk);
         {host_mode, aps, bw_lo, bw_hi} <= {2'(v), 2'h2};
         repeat (3) @(posedge ref_clk);
         chk("hw_recovery", 8'h07, {5'h0, pre});
         chk("hw_tx_path", {5'h0, {3{1'(v)}}}, {5'h0, atx});
         chk("hw_narrow_bw", 8'h07, {5'h0, nbw});
      end
      host_mode <= 1'b1;
      $display("test strap mode done");
      stream_on <= 1'b1;
      repeat (30000) @(posedge ref_clk);
      chk("link_faults", 8'h00, {5'h0, bad});
      chk("stream_live", 8'h01, {7'h0, live});
      chk("running", 8'h01, {7'h0, run});
      chk("super_seen", 8'h01, {7'h0, nsup > 0});
      $display("test stream done");
      end_of_test();
   end
endmodule // tb_top
